// File: src/ktc_keyed_tx.sv
// keyed transmitter control: power, timeout and code encoder
`include "ktc_defines.svh"

module ktc_keyed_tx #(
  parameter logic [20:0] IDLE_CYCLES = 21'(`KTC_IDLE_XTAL_CYCLES),
  parameter ktc_pkg::ktc_long_t TO_STEP_CYC = 40'(`KTC_MS2CYC(`KTC_TO_STEP_MS)),
  parameter ktc_pkg::ktc_bit_t BIT_STEP_CYC = 17'(`KTC_US2CYC(`KTC_BIT_STEP_US))
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // enable pins
  input wire logic tx_enable_in_1,
  input wire logic tx_enable_in_2,
  input wire logic tx_enable_in_3,
  input wire logic tx_enable_in_4,
  // external settings
  input wire logic [1:0] timeout_set_pin,
  input wire logic [2:0] rateSel,
  input wire logic [19:0] otpCode,
  // transmitter controls
  output logic paOn,
  output logic pllRun,
  output logic chipPowered,
  output logic [5:0] pllDivRatio,
  output logic timedOut
);
  import ktc_pkg::*;

  // limits scale from one step each, so a short test keeps the documented ratios
  localparam ktc_long_t TO_CYC_0 = 40'(TO_STEP_CYC * 40'(`KTC_TO_STEPS_0));
  localparam ktc_long_t TO_CYC_1 = 40'(TO_STEP_CYC * 40'(`KTC_TO_STEPS_1));
  localparam ktc_long_t TO_CYC_2 = 40'(TO_STEP_CYC * 40'(`KTC_TO_STEPS_2));
  localparam ktc_long_t TO_CYC_3 = 40'(TO_STEP_CYC * 40'(`KTC_TO_STEPS_3));
  localparam ktc_bit_t BIT_CYC_0 = 17'(BIT_STEP_CYC * 17'(`KTC_BIT_STEPS_0));
  localparam ktc_bit_t BIT_CYC_1 = 17'(BIT_STEP_CYC * 17'(`KTC_BIT_STEPS_1));
  localparam ktc_bit_t BIT_CYC_2 = 17'(BIT_STEP_CYC * 17'(`KTC_BIT_STEPS_2));
  localparam ktc_bit_t BIT_CYC_3 = 17'(BIT_STEP_CYC * 17'(`KTC_BIT_STEPS_3));
  localparam ktc_bit_t BIT_CYC_4 = 17'(BIT_STEP_CYC * 17'(`KTC_BIT_STEPS_4));

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, a change counts once stages two and three agree
  logic [8:0] pinRaw;
  logic [8:0] pinS1_r, pinS2_r, pinS3_r, pinStable_r;
  logic [8:0] pinAgree;
  assign pinRaw = {rateSel, timeout_set_pin,
                   tx_enable_in_4, tx_enable_in_3, tx_enable_in_2, tx_enable_in_1};
  assign pinAgree = ~(pinS2_r ^ pinS3_r);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinS1_r <= '0;
      pinS2_r <= '0;
      pinS3_r <= '0;
      pinStable_r <= '0;
    end else begin
      pinS1_r <= pinRaw;
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
      pinStable_r <= (pinAgree & pinS3_r) | (~pinAgree & pinStable_r);
    end
  end

  logic [3:0] keys, keyPrev_r;
  logic [1:0] toSel;
  logic [2:0] rateIdx;
  logic anyKey, keyChange;
  assign keys = pinStable_r[`KTC_PIN_KEY_LSB +: 4];
  assign toSel = pinStable_r[`KTC_PIN_TO_LSB +: 2];
  assign rateIdx = pinStable_r[`KTC_PIN_RATE_LSB +: 3];
  assign anyKey = |keys;
  assign keyChange = keys != keyPrev_r;

  always_ff @(posedge core_clk) begin
    if (rst) keyPrev_r <= '0;
    else keyPrev_r <= keys;
  end

  ////////////////////////////////////////////////////////////////////////////
  // idle power-down and wake
  logic [20:0] idleCnt_r;
  logic chipPowered_r, chipPowered_nxt, pllRun_r;
  logic [5:0] pllDiv_r;

  always_comb begin
    chipPowered_nxt = chipPowered_r;
    if (anyKey) chipPowered_nxt = 1'b1;
    else if (idleCnt_r > IDLE_CYCLES) chipPowered_nxt = 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (rst) idleCnt_r <= '0;
    else if (anyKey || keyChange) idleCnt_r <= '0;
    else if (chipPowered_r && idleCnt_r <= IDLE_CYCLES) idleCnt_r <= idleCnt_r + 21'd1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      chipPowered_r <= 1'b0;
      pllRun_r <= 1'b0;
      pllDiv_r <= `KTC_PLL_DIV;
    end else begin
      chipPowered_r <= chipPowered_nxt;
      pllRun_r <= chipPowered_nxt;
      pllDiv_r <= `KTC_PLL_DIV;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stuck-input timeout
  ktc_long_t toCnt_r, toLimit;
  logic timedOut_r;

  always_comb begin
    case (toSel)
      2'd0: toLimit = TO_CYC_0;
      2'd1: toLimit = TO_CYC_1;
      2'd2: toLimit = TO_CYC_2;
      default: toLimit = TO_CYC_3;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) toCnt_r <= '0;
    else if (keyChange || !anyKey) toCnt_r <= '0;
    else if (toCnt_r < toLimit) toCnt_r <= toCnt_r + 40'd1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) timedOut_r <= 1'b0;
    else if (!anyKey) timedOut_r <= 1'b0;
    else if (!keyChange && toCnt_r >= toLimit) timedOut_r <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // code encoder: sync 1T high 31T low, then 24 bits of 4T each
  ktc_state_e state_r;
  ktc_bit_t tCnt_r, bitLimit;
  logic [5:0] slot_r;
  logic [4:0] bitIdx_r;
  logic [23:0] frame_r;
  logic go, tick, curBit, encLevel, paOn_r;

  always_comb begin
    case (rateIdx)
      3'd0: bitLimit = BIT_CYC_0;
      3'd1: bitLimit = BIT_CYC_1;
      3'd2: bitLimit = BIT_CYC_2;
      3'd3: bitLimit = BIT_CYC_3;
      default: bitLimit = BIT_CYC_4;
    endcase
  end

  assign go = anyKey && !timedOut_r && chipPowered_r;
  assign tick = tCnt_r == bitLimit - 17'd1;
  assign curBit = frame_r[5'd23 - bitIdx_r];

  always_ff @(posedge core_clk) begin
    if (rst || !go) begin
      state_r <= KTC_IDLE;
      tCnt_r <= '0;
      slot_r <= '0;
      bitIdx_r <= '0;
    end else begin
      tCnt_r <= tick ? '0 : tCnt_r + 17'd1;
      case (state_r)
        KTC_IDLE: begin
          state_r <= KTC_SYNC;
          tCnt_r <= '0;
          slot_r <= '0;
        end
        KTC_SYNC: if (tick) begin
          if (slot_r == `KTC_SYNC_LAST) begin
            state_r <= KTC_BITS;
            slot_r <= '0;
            bitIdx_r <= '0;
          end else slot_r <= slot_r + 6'd1;
        end
        KTC_BITS: if (tick) begin
          if (slot_r == `KTC_BIT_LAST) begin
            slot_r <= '0;
            if (bitIdx_r == `KTC_FRAME_LAST) state_r <= KTC_IDLE;
            else bitIdx_r <= bitIdx_r + 5'd1;
          end else slot_r <= slot_r + 6'd1;
        end
        default: state_r <= KTC_IDLE;
      endcase
    end
  end

  // code and key set captured at each frame start
  always_ff @(posedge core_clk) begin
    if (rst) frame_r <= '0;
    else if (state_r == KTC_IDLE && go) frame_r <= {otpCode, keys};
  end

  always_comb begin
    encLevel = 1'b0;
    if (state_r == KTC_SYNC) encLevel = slot_r == 6'd0;
    else if (state_r == KTC_BITS)
      encLevel = slot_r < (curBit ? `KTC_ONE_HIGH : `KTC_ZERO_HIGH);
  end

  always_ff @(posedge core_clk) begin
    if (rst) paOn_r <= 1'b0;
    else paOn_r <= go && encLevel;
  end

  assign paOn = paOn_r;
  assign pllRun = pllRun_r;
  assign chipPowered = chipPowered_r;
  assign pllDivRatio = pllDiv_r;
  assign timedOut = timedOut_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_sync_start;
    state_r == KTC_SYNC && slot_r == 6'd0 && tCnt_r == 17'd0;
  endsequence
  sequence s_frame_go;
    state_r == KTC_IDLE && go;
  endsequence

  property p_pa_off_idle;
    !anyKey |=> !paOn_r;
  endproperty
  a_pa_off_idle: assert property (p_pa_off_idle) else $error("amp on with inputs low");
  property p_pll_runs;
    chipPowered_r |-> pllRun_r;
  endproperty
  a_pll_runs: assert property (p_pll_runs) else $error("loop off while powered");
  property p_power_down;
    (!anyKey && idleCnt_r > IDLE_CYCLES) |=> !chipPowered_r;
  endproperty
  a_power_down: assert property (p_power_down) else $error("no power down");
  property p_wake;
    anyKey |=> chipPowered_r ##1 pllRun_r;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_timeout_stop;
    timedOut_r |=> !paOn_r;
  endproperty
  a_timeout_stop: assert property (p_timeout_stop) else $error("amp on after timeout");
  property p_timeout_set;
    (anyKey && !keyChange && toCnt_r >= toLimit) |=> timedOut_r;
  endproperty
  a_timeout_set: assert property (p_timeout_set) else $error("timeout missed");
  property p_div32;
    pllDiv_r == `KTC_PLL_DIV;
  endproperty
  a_div32: assert property (p_div32) else $error("divider not 32");
  property p_key_latch;
    s_frame_go |=> frame_r == {otpCode, $past(keys)};
  endproperty
  a_key_latch: assert property (p_key_latch) else $error("frame not captured");
  property p_sync_high;
    (s_sync_start ##0 go) |=> paOn_r;
  endproperty
  a_sync_high: assert property (p_sync_high) else $error("sync pulse missing");
  property p_restart;
    keyChange |=> idleCnt_r == 21'd0 && toCnt_r == 40'd0;
  endproperty
  a_restart: assert property (p_restart) else $error("counts not restarted");
endmodule

// File: pkg/ktc_defines.svh
// constants for the keyed transmit control block
`ifndef KTC_DEFINES_SVH
`define KTC_DEFINES_SVH

`define KTC_CLK_MHZ 125
`define KTC_IDLE_XTAL_CYCLES 1000000
`define KTC_PLL_DIV 6'h20

// timeout per setting, in steps of 2.5 s (7.5, 20, 75, 750 s)
`define KTC_TO_STEP_MS 2500
`define KTC_TO_STEPS_0 3
`define KTC_TO_STEPS_1 8
`define KTC_TO_STEPS_2 30
`define KTC_TO_STEPS_3 300
`define KTC_MS2CYC(ms) (64'(ms) * 64'd1000 * 64'(`KTC_CLK_MHZ))

// slot (T) width per rate setting, a bit being 4 slots, in steps of 10 us (0.12 to 0.50 ms)
`define KTC_BIT_STEP_US 10
`define KTC_BIT_STEPS_0 12
`define KTC_BIT_STEPS_1 16
`define KTC_BIT_STEPS_2 25
`define KTC_BIT_STEPS_3 34
`define KTC_BIT_STEPS_4 50
`define KTC_US2CYC(us) ((us) * `KTC_CLK_MHZ)

// frame layout
`define KTC_SYNC_LAST 6'h1f
`define KTC_BIT_LAST 6'h03
`define KTC_ONE_HIGH 6'h03
`define KTC_ZERO_HIGH 6'h01
`define KTC_FRAME_LAST 5'h17

// pin vector layout
`define KTC_PIN_KEY_LSB 0
`define KTC_PIN_TO_LSB 4
`define KTC_PIN_RATE_LSB 6

`endif

// File: pkg/ktc_pkg.sv
// types for the keyed transmit control block
package ktc_pkg;
  typedef enum logic [1:0] {KTC_IDLE, KTC_SYNC, KTC_BITS} ktc_state_e;
  typedef logic [39:0] ktc_long_t;
  typedef logic [16:0] ktc_bit_t;
endpackage

// File: verification/ktc_button_model.sv
// push-button model driving the four enable pins
module ktc_button_model (
  // button states from the bench, bit 0 is the first pin
  input wire logic [3:0] pressed,
  // enable pins, active high, low when released
  output logic tx_enable_in_1,
  output logic tx_enable_in_2,
  output logic tx_enable_in_3,
  output logic tx_enable_in_4
);
  timeunit 1ns;
  timeprecision 1ps;
  assign {tx_enable_in_4, tx_enable_in_3, tx_enable_in_2, tx_enable_in_1} = pressed;
endmodule

// File: verification/testbench.sv
// self-checking bench for the keyed transmit control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IDLE = 20;
  localparam int TO_STEP = 25;
  localparam int BIT_STEP = 1;
  localparam int TO0 = 3 * TO_STEP;
  localparam int TO1 = 8 * TO_STEP;
  localparam int TO2 = 30 * TO_STEP;
  localparam int TO3 = 300 * TO_STEP;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] keys = 4'h0;
  logic [1:0] toSet = 2'h3;
  logic [2:0] rate = 3'h0;
  logic [19:0] code = 20'h5_a3c9;
  logic e1, e2, e3, e4, paOn, pllRun, chipPowered, timedOut;
  logic [5:0] divRatio;
  int n_mismatch = 0;
  int n_checks = 0;
  always #4 core_clk = ~core_clk;
  ktc_button_model ktc_button_model_inst (.pressed(keys), .tx_enable_in_1(e1),
    .tx_enable_in_2(e2), .tx_enable_in_3(e3), .tx_enable_in_4(e4));
  ktc_keyed_tx #(.IDLE_CYCLES(21'(IDLE)), .TO_STEP_CYC(40'(TO_STEP)),
    .BIT_STEP_CYC(17'(BIT_STEP))) ktc_keyed_tx_inst (
    .core_clk(core_clk), .rst(rst), .tx_enable_in_1(e1), .tx_enable_in_2(e2),
    .tx_enable_in_3(e3), .tx_enable_in_4(e4), .timeout_set_pin(toSet), .rateSel(rate),
    .otpCode(code), .paOn(paOn), .pllRun(pllRun), .chipPowered(chipPowered),
    .pllDivRatio(divRatio), .timedOut(timedOut));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // bounded wait for paOn (0), timedOut (1) or chipPowered (2) to reach v
  task automatic waitsig(input int s, input logic v, input int lim, output int n);
    n = 0;
    while ((s == 0 ? paOn : s == 1 ? timedOut : chipPowered) !== v) begin
      cyc(1);
      n++;
      if (n > lim) begin
        n_mismatch++;
        $display("[FAIL] %0t wait ran out", $time);
        finish_test();
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check(paOn, 0, "pa after reset");
    check(chipPowered, 0, "power after reset");
    check(timedOut, 0, "timeout after reset");
    check(divRatio, 32, "loop divider");
    $display("reset test done");
  endtask
  // one whole frame compared cycle by cycle against the expected waveform
  task automatic t_frame(input logic [2:0] r, input int t, input logic [3:0] k,
                         input logic [19:0] cd);
    int n, b, p;
    logic [23:0] w;
    logic exp;
    rate = r;
    code = cd;
    cyc(8);
    keys = k;
    w = {code, k};
    waitsig(0, 1'b1, 20, n);
    for (int c = 0; c < 128 * t; c++) begin
      b = (c - 32 * t) / (4 * t);
      p = (c - 32 * t) % (4 * t);
      exp = (c < 32 * t) ? (c < t) : (p < (w[23 - b] ? 3 * t : t));
      check(paOn, exp, "frame level");
      cyc(1);
    end
    keys = 4'h0;
    cyc(6);
    check(paOn, 0, "pa after release");
    $display("frame test done");
  endtask
  task automatic t_timeout(input logic [1:0] s, input int lim);
    int n;
    logic hi = 1'b0;
    toSet = s;
    cyc(8);
    keys = 4'h1;
    waitsig(1, 1'b1, lim + 12, n);
    check(n >= lim && n <= lim + 10, 1, "timeout length");
    repeat (300) begin
      cyc(1);
      hi |= paOn;
    end
    check(hi, 0, "pa after timeout");
    keys = 4'h0;
    cyc(6);
    check(timedOut, 0, "timeout clear");
    $display("timeout test done");
  endtask
  task automatic t_restart;
    int n;
    toSet = 2'h0;
    keys = 4'h1;
    cyc(40);
    keys = 4'h3;
    waitsig(1, 1'b1, TO0 + 12, n);
    check(n >= TO0 - 5 && n <= TO0 + 12, 1, "timeout restart");
    keys = 4'h0;
    cyc(6);
    $display("restart test done");
  endtask
  task automatic t_idle;
    int n;
    keys = 4'h1;
    cyc(8);
    keys = 4'h0;
    waitsig(2, 1'b0, 40, n);
    check(n >= IDLE + 2 && n <= IDLE + 10, 1, "idle power down");
    check(pllRun, 0, "loop off with chip");
    keys = 4'h8;
    waitsig(2, 1'b1, 8, n);
    check(pllRun, 1, "loop on with chip");
    keys = 4'h0;
    $display("idle test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(16);
    rst = 1'b0;
    cyc(2);
    t_reset();
    t_frame(3'h0, 12 * BIT_STEP, 4'h5, 20'h5_a3c9);
    t_frame(3'h4, 50 * BIT_STEP, 4'ha, 20'ha_5c36);
    t_frame(3'h2, 25 * BIT_STEP, 4'hf, 20'h0_f0f1);
    t_frame(3'h1, 16 * BIT_STEP, 4'h1, 20'hf_0f0e);
    t_frame(3'h3, 34 * BIT_STEP, 4'h8, 20'h3_9c6a);
    t_timeout(2'h0, TO0);
    t_timeout(2'h1, TO1);
    t_timeout(2'h2, TO2);
    t_timeout(2'h3, TO3);
    t_restart();
    t_idle();
    finish_test();
  end
endmodule
